/* File: design/smaw_pkg.sv */
`default_nettype none

package smaw_pkg;

  // Bus geometry
  localparam int unsigned AXIL_ADDR_W = 8;
  localparam int unsigned AXIL_DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_PORT_A_DATA   = 8'h00;
  localparam logic [7:0] OFS_KBD_STAT_CTRL = 8'h04;
  localparam logic [7:0] OFS_KBD_IRQ_EN    = 8'h08;
  localparam logic [7:0] OFS_CONFIG_ONE    = 8'h0c;
  localparam logic [7:0] OFS_CONFIG_TWO    = 8'h10;

  // Field positions
  localparam int unsigned WAKE_LATCH_BIT = 6;
  localparam int unsigned KBD_FLAG_BIT   = 3;
  localparam int unsigned KBD_ACK_BIT    = 2;
  localparam int unsigned KBD_MASK_BIT   = 1;
  localparam int unsigned WAKE_IE_BIT    = 6;
  localparam int unsigned PERIOD_SEL_BIT = 0;
  localparam int unsigned OSC_RUN_BIT    = 1;

  // Values after reset
  localparam logic RST_KBD_MASK   = 1'b0;
  localparam logic RST_WAKE_IE    = 1'b0;
  localparam logic RST_PERIOD_SEL = 1'b0;
  localparam logic RST_OSC_RUN    = 1'b0;

  // Overflow counts in wakeup clock ticks
  localparam int unsigned SHORT_COUNT = 512;
  localparam int unsigned LONG_COUNT  = 16384;
  localparam int unsigned CNT_W       = 15;

  // Responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register selector
  typedef enum logic [2:0] {
    SEL_PORT_A,
    SEL_KBD_STAT,
    SEL_KBD_IE,
    SEL_CFG_ONE,
    SEL_CFG_TWO,
    SEL_NONE
  } smaw_sel_type;

  typedef struct packed {
    logic [AXIL_ADDR_W-1:0]   awaddr;
    logic                     awvalid;
    logic [AXIL_DATA_W-1:0]   wdata;
    logic [AXIL_DATA_W/8-1:0] wstrb;
    logic                     wvalid;
    logic                     bready;
    logic [AXIL_ADDR_W-1:0]   araddr;
    logic                     arvalid;
    logic                     rready;
  } smaw_axil_req_type;

  typedef struct packed {
    logic                   awready;
    logic                   wready;
    logic [1:0]             bresp;
    logic                   bvalid;
    logic                   arready;
    logic [AXIL_DATA_W-1:0] rdata;
    logic [1:0]             rresp;
    logic                   rvalid;
  } smaw_axil_rsp_type;

endpackage : smaw_pkg

`default_nettype wire

/* File: design/smaw_axil_slave.sv */
`default_nettype none

module smaw_axil_slave (
  // Clock and reset
  input  wire logic                            core_clk_i,
  input  wire logic                            arst_n_i,
  // Bus
  input  wire smaw_pkg::smaw_axil_req_type     axil_req_i,
  output var  smaw_pkg::smaw_axil_rsp_type     axil_rsp_o,
  // Register write side
  output logic                                 wr_en_o,
  output logic [smaw_pkg::AXIL_ADDR_W-1:0]     wr_addr_o,
  output logic [smaw_pkg::AXIL_DATA_W-1:0]     wr_data_o,
  output logic [smaw_pkg::AXIL_DATA_W/8-1:0]   wr_strb_o,
  input  wire logic                            wr_ok_i,
  // Register read side
  output logic [smaw_pkg::AXIL_ADDR_W-1:0]     rd_addr_o,
  input  wire logic [smaw_pkg::AXIL_DATA_W-1:0] rd_data_i,
  input  wire logic                            rd_ok_i
);

  typedef struct packed {
    logic                                aw_got;
    logic                                w_got;
    logic [smaw_pkg::AXIL_ADDR_W-1:0]    addr;
    logic [smaw_pkg::AXIL_DATA_W-1:0]    data;
    logic [smaw_pkg::AXIL_DATA_W/8-1:0]  strb;
    logic                                bvalid;
    logic [1:0]                          bresp;
    logic                                rvalid;
    logic [1:0]                          rresp;
    logic [smaw_pkg::AXIL_DATA_W-1:0]    rdata;
  } smaw_slv_state_type;

  smaw_slv_state_type state_reg;
  smaw_slv_state_type state_next;
  logic               aw_fire;
  logic               w_fire;
  logic               ar_fire;

  // Address and data may arrive in either order; held until both are in
  assign aw_fire = axil_req_i.awvalid & ~state_reg.aw_got & ~state_reg.bvalid;
  assign w_fire  = axil_req_i.wvalid & ~state_reg.w_got & ~state_reg.bvalid;
  assign ar_fire = axil_req_i.arvalid & ~state_reg.rvalid;

  always_comb begin
    state_next = state_reg;
    if (aw_fire) begin
      state_next.aw_got = 1'b1;
      state_next.addr   = axil_req_i.awaddr;
    end
    if (w_fire) begin
      state_next.w_got = 1'b1;
      state_next.data  = axil_req_i.wdata;
      state_next.strb  = axil_req_i.wstrb;
    end
    if (state_reg.aw_got && state_reg.w_got) begin
      state_next.aw_got = 1'b0;
      state_next.w_got  = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp  = wr_ok_i ? smaw_pkg::RESP_OKAY : smaw_pkg::RESP_SLVERR;
    end else if (state_reg.bvalid && axil_req_i.bready) begin
      state_next.bvalid = 1'b0;
    end
    if (ar_fire) begin
      state_next.rvalid = 1'b1;
      state_next.rdata  = rd_data_i;
      state_next.rresp  = rd_ok_i ? smaw_pkg::RESP_OKAY : smaw_pkg::RESP_SLVERR;
    end else if (state_reg.rvalid && axil_req_i.rready) begin
      state_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign axil_rsp_o.awready = ~state_reg.aw_got & ~state_reg.bvalid;
  assign axil_rsp_o.wready  = ~state_reg.w_got & ~state_reg.bvalid;
  assign axil_rsp_o.bvalid  = state_reg.bvalid;
  assign axil_rsp_o.bresp   = state_reg.bresp;
  assign axil_rsp_o.arready = ~state_reg.rvalid;
  assign axil_rsp_o.rvalid  = state_reg.rvalid;
  assign axil_rsp_o.rdata   = state_reg.rdata;
  assign axil_rsp_o.rresp   = state_reg.rresp;

  assign wr_en_o   = state_reg.aw_got & state_reg.w_got;
  assign wr_addr_o = state_reg.addr;
  assign wr_data_o = state_reg.data;
  assign wr_strb_o = state_reg.strb;
  assign rd_addr_o = axil_req_i.araddr;

endmodule // smaw_axil_slave

`default_nettype wire

/* File: design/smaw_wake_counter.sv */
`default_nettype none

module smaw_wake_counter #(
  parameter int unsigned CNT_W       = smaw_pkg::CNT_W,
  parameter int unsigned SHORT_COUNT = smaw_pkg::SHORT_COUNT,
  parameter int unsigned LONG_COUNT  = smaw_pkg::LONG_COUNT
) (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic arst_n_i,
  // Control
  input  wire logic run_i,
  input  wire logic tick_i,
  input  wire logic period_select_i,
  // Overflow
  output logic      req_pulse_o
);

  typedef struct packed {
    logic             run_d;
    logic [CNT_W-1:0] last;
    logic [CNT_W-1:0] cnt;
    logic             pulse;
  } smaw_cnt_state_type;

  smaw_cnt_state_type state_reg;
  smaw_cnt_state_type state_next;

  always_comb begin
    state_next       = state_reg;
    state_next.run_d = run_i;
    state_next.pulse = 1'b0;
    if (!run_i) begin
      state_next.cnt = '0;
    end else if (!state_reg.run_d) begin
      // Period frozen at entry so a late change cannot shorten a wait
      state_next.cnt  = '0;
      state_next.last = period_select_i ? CNT_W'(SHORT_COUNT - 1)
                                        : CNT_W'(LONG_COUNT - 1);
    end else if (tick_i) begin
      if (state_reg.cnt == state_reg.last) begin
        state_next.cnt   = '0;
        state_next.pulse = 1'b1;
      end else begin
        state_next.cnt = state_reg.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign req_pulse_o = state_reg.pulse;

endmodule // smaw_wake_counter

`default_nettype wire

/* File: design/smaw_auto_wakeup.sv */
// Behaviour
// - Oscillator ticks and counters idle in run mode; active only in stop.
// - Request latched only while wakeup interrupt enable is set.
// - Wakeup latch reads as read-only bit 6 of port A data.
// - No direction, pullup or other control exists for that bit.
// - Counter ticks from RC oscillator, or doubled bus clock when run-in-stop set.
// - Overflow makes a request pulse, latched and sent to keyboard logic.
// - Request serviced only when enabled; raised on shared keyboard interrupt.
// - Period select 1 gives short count, 0 gives long count.
// - Acknowledge write and reset clear the wakeup latch.
// - Latch reads true state whatever the enable bit is.
// - Wakeup logic stays inactive in wait mode.
// - Counter restarts from zero on every stop entry.
// - Writing 1 to acknowledge clears requests; acknowledge reads as 0.
// - Mask set blocks keyboard and wakeup interrupt requests.
//
// The AXI4-Lite register port and the register addresses were left to the implementer.

`default_nettype none

module smaw_auto_wakeup #(
  parameter int unsigned SHORT_COUNT = smaw_pkg::SHORT_COUNT,
  parameter int unsigned LONG_COUNT  = smaw_pkg::LONG_COUNT
) (
  // Clock and reset
  input  wire logic                        core_clk_i,
  input  wire logic                        arst_n_i,
  // Register bus
  input  wire smaw_pkg::smaw_axil_req_type axil_req_i,
  output var  smaw_pkg::smaw_axil_rsp_type axil_rsp_o,
  // Power modes
  input  wire logic                        stop_mode_i,
  input  wire logic                        wait_mode_i,
  // Wakeup clock sources
  input  wire logic                        wakeup_rc_osc_i,
  input  wire logic                        double_bus_clock_i,
  // Keyboard interrupt logic
  input  wire logic                        kbd_pin_flag_i,
  output logic                             wakeup_request_pulse_o,
  output logic                             wakeup_latch_flag_o,
  output logic                             kbd_ack_pulse_o,
  output logic                             kbd_irq_o
);

  typedef struct packed {
    logic kbd_irq_mask;
    logic wakeup_irq_enable;
    logic period_select;
    logic osc_run_in_stop;
    logic wakeup_latch_flag;
    logic rc_prev;
    logic bus_prev;
    logic ack_pulse;
    logic irq;
  } smaw_top_state_type;

  localparam smaw_top_state_type RESET_STATE = '{
    kbd_irq_mask:      smaw_pkg::RST_KBD_MASK,
    wakeup_irq_enable: smaw_pkg::RST_WAKE_IE,
    period_select:     smaw_pkg::RST_PERIOD_SEL,
    osc_run_in_stop:   smaw_pkg::RST_OSC_RUN,
    default:           1'b0
  };

  smaw_top_state_type                    state_reg;
  smaw_top_state_type                    state_next;
  logic                                  wr_en;
  logic [smaw_pkg::AXIL_ADDR_W-1:0]      wr_addr;
  logic [smaw_pkg::AXIL_DATA_W-1:0]      wr_data;
  logic [smaw_pkg::AXIL_DATA_W/8-1:0]    wr_strb;
  logic                                  wr_ok;
  logic [smaw_pkg::AXIL_ADDR_W-1:0]      rd_addr;
  logic [smaw_pkg::AXIL_DATA_W-1:0]      rd_data;
  logic                                  rd_ok;
  logic                                  run;
  logic                                  tick;
  logic                                  ovf_pulse;
  smaw_pkg::smaw_sel_type                wr_sel;
  smaw_pkg::smaw_sel_type                rd_sel;

  // Word-aligned decode; unaligned or unknown offsets select nothing
  function automatic smaw_pkg::smaw_sel_type reg_select(
    input logic [smaw_pkg::AXIL_ADDR_W-1:0] addr
  );
    case (addr)
      smaw_pkg::OFS_PORT_A_DATA:   reg_select = smaw_pkg::SEL_PORT_A;
      smaw_pkg::OFS_KBD_STAT_CTRL: reg_select = smaw_pkg::SEL_KBD_STAT;
      smaw_pkg::OFS_KBD_IRQ_EN:    reg_select = smaw_pkg::SEL_KBD_IE;
      smaw_pkg::OFS_CONFIG_ONE:    reg_select = smaw_pkg::SEL_CFG_ONE;
      smaw_pkg::OFS_CONFIG_TWO:    reg_select = smaw_pkg::SEL_CFG_TWO;
      default:                     reg_select = smaw_pkg::SEL_NONE;
    endcase
  endfunction

  smaw_axil_slave smaw_axil_slave_i (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .axil_req_i (axil_req_i),
    .axil_rsp_o (axil_rsp_o),
    .wr_en_o    (wr_en),
    .wr_addr_o  (wr_addr),
    .wr_data_o  (wr_data),
    .wr_strb_o  (wr_strb),
    .wr_ok_i    (wr_ok),
    .rd_addr_o  (rd_addr),
    .rd_data_i  (rd_data),
    .rd_ok_i    (rd_ok)
  );

  // Wait mode overrides stop so the counter never runs there
  assign run = stop_mode_i & ~wait_mode_i;

  // Source chosen by run-in-stop; ticks are rising edges of the source
  assign tick = state_reg.osc_run_in_stop
              ? (double_bus_clock_i & ~state_reg.bus_prev)
              : (wakeup_rc_osc_i & ~state_reg.rc_prev);

  smaw_wake_counter #(
    .CNT_W       (smaw_pkg::CNT_W),
    .SHORT_COUNT (SHORT_COUNT),
    .LONG_COUNT  (LONG_COUNT)
  ) smaw_wake_counter_i (
    .core_clk_i      (core_clk_i),
    .arst_n_i        (arst_n_i),
    .run_i           (run),
    .tick_i          (tick),
    .period_select_i (state_reg.period_select),
    .req_pulse_o     (ovf_pulse)
  );

  assign wr_sel = reg_select(wr_addr);
  assign rd_sel = reg_select(rd_addr);
  assign wr_ok  = (wr_sel != smaw_pkg::SEL_NONE);
  assign rd_ok  = (rd_sel != smaw_pkg::SEL_NONE);

  always_comb begin
    logic ack;
    logic set;
    ack                  = 1'b0;
    set                  = 1'b0;
    state_next           = state_reg;
    state_next.rc_prev   = wakeup_rc_osc_i;
    state_next.bus_prev  = double_bus_clock_i;
    // Only byte lane 0 carries fields
    if (wr_en && wr_strb[0]) begin
      case (wr_sel)
        smaw_pkg::SEL_KBD_STAT: begin
          state_next.kbd_irq_mask = wr_data[smaw_pkg::KBD_MASK_BIT];
          ack                     = wr_data[smaw_pkg::KBD_ACK_BIT];
        end
        smaw_pkg::SEL_KBD_IE: begin
          state_next.wakeup_irq_enable = wr_data[smaw_pkg::WAKE_IE_BIT];
        end
        smaw_pkg::SEL_CFG_ONE: begin
          state_next.period_select = wr_data[smaw_pkg::PERIOD_SEL_BIT];
        end
        smaw_pkg::SEL_CFG_TWO: begin
          state_next.osc_run_in_stop = wr_data[smaw_pkg::OSC_RUN_BIT];
        end
        // Port A bit 6 is read-only; nothing else on it to write
        default: begin
          ack = 1'b0;
        end
      endcase
    end
    set = ovf_pulse & state_reg.wakeup_irq_enable;
    // A new request in the acknowledge cycle survives the clear
    state_next.wakeup_latch_flag = set | (state_reg.wakeup_latch_flag & ~ack);
    state_next.ack_pulse         = ack;
    state_next.irq = (state_next.wakeup_latch_flag | kbd_pin_flag_i)
                   & ~state_next.kbd_irq_mask;
  end

  always_comb begin
    rd_data = '0;
    case (rd_sel)
      smaw_pkg::SEL_PORT_A: begin
        rd_data[smaw_pkg::WAKE_LATCH_BIT] = state_reg.wakeup_latch_flag;
      end
      smaw_pkg::SEL_KBD_STAT: begin
        rd_data[smaw_pkg::KBD_FLAG_BIT] = state_reg.wakeup_latch_flag | kbd_pin_flag_i;
        rd_data[smaw_pkg::KBD_MASK_BIT] = state_reg.kbd_irq_mask;
        rd_data[smaw_pkg::KBD_ACK_BIT]  = 1'b0;
      end
      smaw_pkg::SEL_KBD_IE: begin
        rd_data[smaw_pkg::WAKE_IE_BIT] = state_reg.wakeup_irq_enable;
      end
      smaw_pkg::SEL_CFG_ONE: begin
        rd_data[smaw_pkg::PERIOD_SEL_BIT] = state_reg.period_select;
      end
      smaw_pkg::SEL_CFG_TWO: begin
        rd_data[smaw_pkg::OSC_RUN_BIT] = state_reg.osc_run_in_stop;
      end
      default: begin
        rd_data = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= RESET_STATE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign wakeup_request_pulse_o = ovf_pulse;
  assign wakeup_latch_flag_o    = state_reg.wakeup_latch_flag;
  assign kbd_ack_pulse_o        = state_reg.ack_pulse;
  assign kbd_irq_o              = state_reg.irq;

endmodule // smaw_auto_wakeup

`default_nettype wire

/* File: tb/smaw_kbd_model.sv */
`default_nettype none

module smaw_kbd_model (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic arst_n_i,
  // Key press and acknowledge
  input  wire logic press_i,
  input  wire logic ack_pulse_i,
  // Pending keyboard request
  output logic      pin_flag_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Acknowledge wins so a press in the ack cycle is lost, as on the real pin logic
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) pin_flag_o <= 1'b0;
    else if (ack_pulse_i) pin_flag_o <= 1'b0;
    else if (press_i) pin_flag_o <= 1'b1;
  end
endmodule // smaw_kbd_model

`default_nettype wire

/* File: tb/smaw_auto_wakeup_monitor.sv */
`default_nettype none

module smaw_auto_wakeup_monitor (
  // Clock and reset
  input wire logic                        core_clk_i,
  input wire logic                        arst_n_i,
  // Bus
  input wire smaw_pkg::smaw_axil_req_type axil_req_i,
  input wire smaw_pkg::smaw_axil_rsp_type axil_rsp_o,
  // Modes and sources
  input wire logic                        stop_mode_i,
  input wire logic                        wait_mode_i,
  input wire logic                        wakeup_rc_osc_i,
  input wire logic                        double_bus_clock_i,
  // Keyboard side
  input wire logic                        kbd_pin_flag_i,
  input wire logic                        wakeup_request_pulse_o,
  input wire logic                        wakeup_latch_flag_o,
  input wire logic                        kbd_ack_pulse_o,
  input wire logic                        kbd_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic rd_porta;
  logic rd_kbd;
  logic run;
  assign run = stop_mode_i && !wait_mode_i;
  assign rd_porta = axil_req_i.arvalid && axil_rsp_o.arready
                    && axil_req_i.araddr == smaw_pkg::OFS_PORT_A_DATA;
  assign rd_kbd = axil_req_i.arvalid && axil_rsp_o.arready
                  && axil_req_i.araddr == smaw_pkg::OFS_KBD_STAT_CTRL;

  a_pulse_single: assert property (
    wakeup_request_pulse_o |=> !wakeup_request_pulse_o) else $error("pulse too long");
  // Two idle cycles so a tick taken on the last run edge may still land
  a_idle_no_pulse: assert property (
    (!run) [*2] |=> !wakeup_request_pulse_o) else $error("pulse outside stop");
  a_latch_cause: assert property (
    $rose(wakeup_latch_flag_o) |-> $past(wakeup_request_pulse_o))
    else $error("latch set without pulse");
  a_latch_clear: assert property (
    $fell(wakeup_latch_flag_o) |-> kbd_ack_pulse_o || $past(kbd_ack_pulse_o)
    || $past(kbd_ack_pulse_o, 2)) else $error("latch cleared without ack");
  a_ack_single: assert property (
    kbd_ack_pulse_o |=> !kbd_ack_pulse_o) else $error("ack pulse too long");
  a_irq_cause: assert property (
    kbd_irq_o |-> wakeup_latch_flag_o || kbd_pin_flag_i || $past(wakeup_latch_flag_o)
    || $past(kbd_pin_flag_i)) else $error("irq without request");
  a_porta_read: assert property (
    rd_porta |=> axil_rsp_o.rvalid
    && axil_rsp_o.rdata == {25'h0, $past(wakeup_latch_flag_o), 6'h0})
    else $error("port A read wrong");
  a_ack_reads_zero: assert property (
    rd_kbd |=> axil_rsp_o.rvalid && !axil_rsp_o.rdata[2] && axil_rsp_o.rdata[7:4] == 4'h0)
    else $error("ack bit read as one");

  c_latch: cover property ($rose(wakeup_latch_flag_o));
  c_ack: cover property (kbd_ack_pulse_o && $past(wakeup_latch_flag_o));
  c_irq: cover property ($rose(kbd_irq_o));
endmodule // smaw_auto_wakeup_monitor

bind smaw_auto_wakeup smaw_auto_wakeup_monitor smaw_auto_wakeup_monitor_i (
  .core_clk_i, .arst_n_i, .axil_req_i, .axil_rsp_o, .stop_mode_i, .wait_mode_i,
  .wakeup_rc_osc_i, .double_bus_clock_i, .kbd_pin_flag_i, .wakeup_request_pulse_o,
  .wakeup_latch_flag_o, .kbd_ack_pulse_o, .kbd_irq_o
);

`default_nettype wire

/* File: tb/smaw_auto_wakeup_tb.sv */
`default_nettype none

module smaw_auto_wakeup_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Short counts keep the long period affordable
  localparam int SHORT_N = 4;
  localparam int LONG_N  = 8;
  logic                        core_clk_i;
  logic                        arst_n_i;
  smaw_pkg::smaw_axil_req_type req;
  smaw_pkg::smaw_axil_rsp_type rsp;
  logic                        stop_mode, wait_mode, rc_osc, dbl_clk, press;
  logic                        kbd_flag, wake_pulse, wake_latch, ack_pulse, kbd_irq;
  logic [31:0]                 rd;
  logic [1:0]                  rr;
  int                          err_count, compares, pulse_cnt;

  smaw_auto_wakeup #(.SHORT_COUNT(SHORT_N), .LONG_COUNT(LONG_N)) smaw_auto_wakeup_i (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .axil_req_i(req), .axil_rsp_o(rsp),
    .stop_mode_i(stop_mode), .wait_mode_i(wait_mode), .wakeup_rc_osc_i(rc_osc),
    .double_bus_clock_i(dbl_clk), .kbd_pin_flag_i(kbd_flag),
    .wakeup_request_pulse_o(wake_pulse), .wakeup_latch_flag_o(wake_latch),
    .kbd_ack_pulse_o(ack_pulse), .kbd_irq_o(kbd_irq));
  smaw_kbd_model smaw_kbd_model_i (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
    .press_i(press), .ack_pulse_i(ack_pulse), .pin_flag_o(kbd_flag));

  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) if (wake_pulse === 1'b1) pulse_cnt++;

  function automatic logic [31:0] bit32(input logic x);
    return {31'h0, x};
  endfunction
  task automatic fail(input string m);
    err_count++;
    $display("mismatch %0t %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) fail(m);
  endtask
  task automatic final_report();
    if (err_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Handshakes judged at the falling edge, where inputs and readies are settled
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw, w, done;
    logic [1:0] er;
    n = 0;
    done = 1'b0;
    er = (a > smaw_pkg::OFS_CONFIG_TWO) ? smaw_pkg::RESP_SLVERR : smaw_pkg::RESP_OKAY;
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    while (!done) begin
      @(negedge core_clk_i);
      aw = req.awvalid && rsp.awready;
      w = req.wvalid && rsp.wready;
      done = rsp.bvalid;
      if (done) chk({30'h0, rsp.bresp}, {30'h0, er}, "write response");
      @(posedge core_clk_i);
      // Ready left high so a following call never re-drives it in the same step
      if (aw) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
      if (++n > 40) begin
        fail("write timeout");
        final_report();
      end
    end
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ar, done;
    n = 0;
    done = 1'b0;
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    while (!done) begin
      @(negedge core_clk_i);
      ar = req.arvalid && rsp.arready;
      done = rsp.rvalid;
      d = rsp.rdata;
      r = rsp.rresp;
      @(posedge core_clk_i);
      if (ar) req.arvalid <= 1'b0;
      if (++n > 40) begin
        fail("read timeout");
        final_report();
      end
    end
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    axi_read(a, rd, rr);
    chk(rd, exp, "register value");
    chk({30'h0, rr}, {30'h0, smaw_pkg::RESP_OKAY}, "read response");
  endtask
  task automatic ticks(input logic src, input int n);
    repeat (n) begin
      if (src) dbl_clk <= 1'b1;
      else rc_osc <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      if (src) dbl_clk <= 1'b0;
      else rc_osc <= 1'b0;
      repeat (2) @(posedge core_clk_i);
    end
  endtask
  task automatic enter_stop();
    stop_mode <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    stop_mode <= 1'b1;
    repeat (2) @(posedge core_clk_i);
  endtask
  task automatic period_run(input logic sel, input logic src);
    int n;
    n = sel ? SHORT_N : LONG_N;
    axi_write(smaw_pkg::OFS_CONFIG_ONE, bit32(sel));
    axi_write(smaw_pkg::OFS_CONFIG_TWO, {30'h0, src, 1'b0});
    enter_stop();
    ticks(!src, n + 1);
    chk(bit32(wake_latch), 32'h0, "idle source counted");
    ticks(src, n - 1);
    enter_stop();
    axi_write(smaw_pkg::OFS_CONFIG_ONE, bit32(!sel));
    ticks(src, n - 1);
    chk(bit32(wake_latch), 32'h0, "latch early");
    ticks(src, 1);
    chk(bit32(wake_latch), 32'h1, "latch at overflow");
    chk(bit32(kbd_irq), 32'h1, "irq missing");
    axi_write(smaw_pkg::OFS_KBD_IRQ_EN, 32'h0);
    chk_reg(smaw_pkg::OFS_PORT_A_DATA, 32'h40);
    axi_write(smaw_pkg::OFS_KBD_IRQ_EN, 32'h40);
    axi_write(smaw_pkg::OFS_KBD_STAT_CTRL, 32'h2);
    repeat (2) @(posedge core_clk_i);
    chk(bit32(kbd_irq), 32'h0, "masked irq");
    axi_write(smaw_pkg::OFS_KBD_STAT_CTRL, 32'h4);
    repeat (3) @(posedge core_clk_i);
    chk(bit32(wake_latch), 32'h0, "ack left latch");
  endtask

  initial begin
    req = '0;
    {arst_n_i, stop_mode, wait_mode, rc_osc, dbl_clk, press} = 6'h0;
    err_count = 0;
    compares = 0;
    repeat (20) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    @(posedge core_clk_i);
    for (int a = 0; a < 5; a++) chk_reg(8'(4 * a), 32'h0);
    axi_read(8'h14, rd, rr);
    chk({30'h0, rr}, {30'h0, smaw_pkg::RESP_SLVERR}, "unmapped response");
    chk(rd, 32'h0, "unmapped data");
    axi_write(8'h14, 32'hff);
    axi_write(smaw_pkg::OFS_PORT_A_DATA, 32'hff);
    chk_reg(smaw_pkg::OFS_PORT_A_DATA, 32'h0);
    axi_write(smaw_pkg::OFS_KBD_STAT_CTRL, 32'h6);
    chk_reg(smaw_pkg::OFS_KBD_STAT_CTRL, 32'h2);
    axi_write(smaw_pkg::OFS_KBD_STAT_CTRL, 32'h0);
    axi_write(smaw_pkg::OFS_KBD_IRQ_EN, 32'h40);
    axi_write(smaw_pkg::OFS_CONFIG_ONE, 32'h1);
    ticks(1'b0, 10);
    chk(pulse_cnt, 32'h0, "pulse in run mode");
    stop_mode <= 1'b1;
    wait_mode <= 1'b1;
    ticks(1'b0, 10);
    chk(pulse_cnt, 32'h0, "pulse in wait mode");
    wait_mode <= 1'b0;
    axi_write(smaw_pkg::OFS_KBD_IRQ_EN, 32'h0);
    enter_stop();
    ticks(1'b0, SHORT_N);
    chk(pulse_cnt, 32'h1, "overflow pulse");
    chk(bit32(wake_latch), 32'h0, "latch while disabled");
    axi_write(smaw_pkg::OFS_KBD_IRQ_EN, 32'h40);
    for (int s = 0; s < 4; s++) period_run(s[1], s[0]);
    press <= 1'b1;
    @(posedge core_clk_i);
    press <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    chk_reg(smaw_pkg::OFS_KBD_STAT_CTRL, 32'h8);
    axi_write(smaw_pkg::OFS_KBD_STAT_CTRL, 32'h4);
    repeat (3) @(posedge core_clk_i);
    chk(bit32(kbd_irq), 32'h0, "irq after ack");
    ticks(1'b1, SHORT_N);
    chk(bit32(wake_latch), 32'h1, "latch before reset");
    arst_n_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    @(posedge core_clk_i);
    chk(bit32(wake_latch), 32'h0, "latch after reset");
    final_report();
  end
endmodule // smaw_auto_wakeup_tb

`default_nettype wire
